// File: rtl/ifw_params.svh
`ifndef IFW_PARAMS_SVH
`define IFW_PARAMS_SVH
`define IFW_OFS_PFLAG 12'h000
`define IFW_OFS_WFLAG 12'h004
`define IFW_OFS_WEDGE 12'h008
`define IFW_OFS_EN1 12'h00c
`define IFW_OFS_EN2 12'h010
`define IFW_OFS_VEC 12'h014
`define IFW_PFLAG_MASK 8'hcd
`define IFW_EN1_MASK 8'h20
`define IFW_EN1_WAKE_BIT 5
`define IFW_BIT_DT 7
`define IFW_BIT_AD 6
`define IFW_BIT_TFH 3
`define IFW_BIT_TFL 2
`define IFW_BIT_EC 0
`define IFW_WEDGE_RESET 8'h00
`define IFW_WAKE_VECTOR 8'h09
`define IFW_EXT_SOURCES 11
`define IFW_RESP_OKAY 2'b00
`define IFW_RESP_SLVERR 2'b10
`endif

// File: rtl/ifw_pkg.sv
package ifw_pkg;
	// Write channel progress of the bus slave.
	typedef enum logic [2:0] {
		IFW_W_IDLE = 3'b001,
		IFW_W_RESP = 3'b010,
		IFW_W_HOLD = 3'b100
	} ifw_wstate_t;
	typedef logic [7:0] ifw_byte_t;
endpackage

// File: rtl/ifw_evt_if.sv
`timescale 1ns/1ps
// Raw event strobes handed from the top to the flag register.
interface ifw_evt_if;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [7:0] flags;
	modport src (output set_vec, output clr_vec, input flags);
	modport dst (input set_vec, input clr_vec, output flags);
endinterface

// File: rtl/ifw_flag_reg.sv
`timescale 1ns/1ps
`include "ifw_params.svh"
// Up to eight sticky request flags (the bits set in IMPL) with write-zero clearing.
module ifw_flag_reg
	import ifw_pkg::*;
#(
	parameter logic [7:0] IMPL = 8'hff
) (
	input wire logic clk,
	input wire logic rst,
	ifw_evt_if.dst evt
);
	ifw_byte_t flag_reg;
	ifw_byte_t flag_next;

	// set wins clear: the event term is ORed after the clear so no request is lost.
	// ones ignored: only the clear vector can lower a bit, never raise it.
	assign flag_next = ((flag_reg & ~evt.clr_vec) | evt.set_vec) & IMPL;

	// flags reset clear; flags only fall on clear writes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_reg <= 8'h00;
		end else begin
			flag_reg <= flag_next;
		end
	end
	assign evt.flags = flag_reg;

	a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
		(evt.set_vec != 8'h00) |=> ((flag_reg & $past(evt.set_vec & IMPL)) == $past(evt.set_vec & IMPL)))
		else $error("flag lost on set");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> ((($past(flag_reg) & ~$past(evt.clr_vec)) & ~flag_reg) == 8'h00))
		else $error("flag fell without clear");
	a_no_sw_set: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> ((flag_reg & ~$past(flag_reg) & ~$past(evt.set_vec)) == 8'h00))
		else $error("flag rose without event");
	c_flag_cleared: cover property (@(posedge clk) disable iff (rst)
		(flag_reg != 8'h00) ##1 (flag_reg == 8'h00));
endmodule

// File: rtl/ifw_top.sv
`timescale 1ns/1ps
`include "ifw_params.svh"
// Request flags for peripheral events and wakeup pins, AXI4-Lite registers.
module ifw_top
	import ifw_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic SLEEP_DIRECT,
	input wire logic DIRECT_TRANSFER_ON,
	input wire logic CONVERSION_IN_PROGRESS,
	input wire logic TIMER_F_16BIT,
	input wire logic [7:0] TIMER_F_HIGH_COUNT,
	input wire logic [7:0] TIMER_F_LOW_COUNT,
	input wire logic [7:0] TIMER_F_HIGH_COMPARE,
	input wire logic [7:0] TIMER_F_LOW_COMPARE,
	input wire logic EVENT_COUNT_16BIT,
	input wire logic EVENT_COUNT_HIGH_OVF,
	input wire logic EVENT_COUNT_LOW_OVF,
	input wire logic [7:0] WAKEUP_PIN,
	input wire logic [7:0] WAKEUP_PIN_SELECT,
	output logic IRQ,
	output logic WAKEUP_REQ,
	output logic PERIPH_REQ,
	output logic [7:0] WAKEUP_VECTOR
);
	// Write and read channel registers.
	ifw_wstate_t wst_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	// Software state, edge history and registered request outputs.
	ifw_byte_t wedge_reg;
	ifw_byte_t en1_reg;
	ifw_byte_t en2_reg;
	ifw_byte_t pin_prev_reg;
	logic pin_valid_reg;
	logic conv_prev_reg;
	logic sleep_prev_reg;
	logic irq_reg;
	logic wreq_reg;
	logic preq_reg;
	logic [7:0] vec_reg;

	ifw_evt_if pevt ();
	ifw_evt_if wevt ();

	// Decoded offset check, shared by read and write paths.
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `IFW_OFS_PFLAG) || (a == `IFW_OFS_WFLAG) ||
			(a == `IFW_OFS_WEDGE) || (a == `IFW_OFS_EN1) ||
			(a == `IFW_OFS_EN2) || (a == `IFW_OFS_VEC);
	endfunction

	// A write commits once both address and data have been taken.
	wire aw_take = S_AXI_AWVALID && !aw_got_reg && (wst_reg == IFW_W_IDLE);
	wire w_take = S_AXI_WVALID && !w_got_reg && (wst_reg == IFW_W_IDLE);
	wire [11:0] wa = aw_got_reg ? awaddr_reg : S_AXI_AWADDR;
	wire [31:0] wd = w_got_reg ? wdata_reg : S_AXI_WDATA;
	wire [3:0] ws = w_got_reg ? wstrb_reg : S_AXI_WSTRB;
	wire wr_fire = (wst_reg == IFW_W_IDLE) && (aw_got_reg || aw_take) && (w_got_reg || w_take);
	wire wr_lane0 = wr_fire && ws[0];
	wire wr_pflag = wr_lane0 && (wa == `IFW_OFS_PFLAG);
	wire wr_wflag = wr_lane0 && (wa == `IFW_OFS_WFLAG);
	wire wr_wedge = wr_lane0 && (wa == `IFW_OFS_WEDGE);
	wire wr_en1 = wr_lane0 && (wa == `IFW_OFS_EN1);
	wire wr_en2 = wr_lane0 && (wa == `IFW_OFS_EN2);

	// Write channel handshake and response.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wst_reg <= IFW_W_IDLE;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bresp_reg <= `IFW_RESP_OKAY;
		end else begin
			unique case (wst_reg)
				IFW_W_IDLE: begin
					if (wr_fire) begin
						wst_reg <= IFW_W_RESP;
						aw_got_reg <= 1'b0;
						w_got_reg <= 1'b0;
						bresp_reg <= is_mapped(wa) ? `IFW_RESP_OKAY : `IFW_RESP_SLVERR;
					end else begin
						if (aw_take) begin
							aw_got_reg <= 1'b1;
							awaddr_reg <= S_AXI_AWADDR;
						end
						if (w_take) begin
							w_got_reg <= 1'b1;
							wdata_reg <= S_AXI_WDATA;
							wstrb_reg <= S_AXI_WSTRB;
						end
					end
				end
				IFW_W_RESP: begin
					if (S_AXI_BREADY) begin
						wst_reg <= IFW_W_HOLD;
					end
				end
				IFW_W_HOLD: begin
					wst_reg <= IFW_W_IDLE;
				end
				default: begin
					wst_reg <= IFW_W_IDLE;
				end
			endcase
		end
	end
	assign S_AXI_AWREADY = aw_take;
	assign S_AXI_WREADY = w_take;
	assign S_AXI_BVALID = (wst_reg == IFW_W_RESP);
	assign S_AXI_BRESP = bresp_reg;

	// Read mux; unused upper bits read as zero.
	wire [11:0] ra = S_AXI_ARADDR;
	wire [7:0] rd_byte =
		(ra == `IFW_OFS_PFLAG) ? pevt.flags :
		(ra == `IFW_OFS_WFLAG) ? wevt.flags :
		(ra == `IFW_OFS_WEDGE) ? wedge_reg :
		(ra == `IFW_OFS_EN1) ? en1_reg :
		(ra == `IFW_OFS_EN2) ? en2_reg :
		(ra == `IFW_OFS_VEC) ? `IFW_WAKE_VECTOR : 8'h00;
	wire ar_take = S_AXI_ARVALID && !arready_reg && !rvalid_reg;

	// Read channel: one cycle ready pulse, data valid on the same edge.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `IFW_RESP_OKAY;
		end else begin
			arready_reg <= ar_take;
			if (ar_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h000000, rd_byte};
				rresp_reg <= is_mapped(ra) ? `IFW_RESP_OKAY : `IFW_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				rvalid_reg <= 1'b0;
			end
		end
	end
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;

	// edge select reset; enables reset to 0.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wedge_reg <= `IFW_WEDGE_RESET;
			en1_reg <= 8'h00;
			en2_reg <= 8'h00;
		end else begin
			if (wr_wedge) wedge_reg <= wd[7:0];
			// reserved writes: reserved bits are masked off and hold zero.
			if (wr_en1) en1_reg <= wd[7:0] & `IFW_EN1_MASK;
			if (wr_en2) en2_reg <= wd[7:0] & `IFW_PFLAG_MASK;
		end
	end

	// Event history for edge detection.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pin_prev_reg <= 8'h00;
			pin_valid_reg <= 1'b0;
			conv_prev_reg <= 1'b0;
			sleep_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= WAKEUP_PIN;
			pin_valid_reg <= 1'b1;
			conv_prev_reg <= CONVERSION_IN_PROGRESS;
			sleep_prev_reg <= SLEEP_DIRECT;
		end
	end

	// direct transfer: sleep pulse while transfer-on is set.
	wire ev_dt = SLEEP_DIRECT && !sleep_prev_reg && DIRECT_TRANSFER_ON;
	wire ev_ad = conv_prev_reg && !CONVERSION_IN_PROGRESS;
	wire hi_eq = (TIMER_F_HIGH_COUNT == TIMER_F_HIGH_COMPARE);
	wire lo_eq = (TIMER_F_LOW_COUNT == TIMER_F_LOW_COMPARE);
	// timer high match in 8-bit mode, high and low match together in 16-bit mode.
	wire ev_tfh = TIMER_F_16BIT ? (hi_eq && lo_eq) : hi_eq;
	// timer low match only in 8-bit mode.
	wire ev_tfl = !TIMER_F_16BIT && lo_eq;
	wire ev_ec = EVENT_COUNT_HIGH_OVF || (!EVENT_COUNT_16BIT && EVENT_COUNT_LOW_OVF);

	assign pevt.set_vec = {ev_dt, ev_ad, 2'b00, ev_tfh, ev_tfl, 1'b0, ev_ec};
	// clear by zero: a written 0 in lane 0 clears, a 1 does nothing.
	assign pevt.clr_vec = wr_pflag ? ~wd[7:0] : 8'h00;
	assign wevt.clr_vec = wr_wflag ? ~wd[7:0] : 8'h00;

	// wakeup sources: the eight pins here; the other three sit outside this block.
	// wakeup edges per pin, polarity chosen per bit.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_wake
			wire rise = WAKEUP_PIN[gi] && !pin_prev_reg[gi];
			wire fall = !WAKEUP_PIN[gi] && pin_prev_reg[gi];
			assign wevt.set_vec[gi] = pin_valid_reg && WAKEUP_PIN_SELECT[gi] &&
				(wedge_reg[gi] ? rise : fall);
		end
	endgenerate

	ifw_flag_reg #(.IMPL(`IFW_PFLAG_MASK)) u_pflag (
		.clk(REF_CLK),
		.rst(RST),
		.evt(pevt)
	);
	ifw_flag_reg #(.IMPL(8'hff)) u_wflag (
		.clk(REF_CLK),
		.rst(RST),
		.evt(wevt)
	);

	// wakeup gate and per-source gates feed the requests.
	wire wake_on = en1_reg[`IFW_EN1_WAKE_BIT] && (wevt.flags != 8'h00);
	wire periph_on = ((pevt.flags & en2_reg) != 8'h00);

	// Registered request outputs; one cycle after the flag, which keeps outputs glitch free.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			irq_reg <= 1'b0;
			wreq_reg <= 1'b0;
			preq_reg <= 1'b0;
			vec_reg <= 8'h00;
		end else begin
			wreq_reg <= wake_on;
			preq_reg <= periph_on;
			irq_reg <= wake_on || periph_on;
			// shared vector for every wakeup pin.
			vec_reg <= wake_on ? `IFW_WAKE_VECTOR : 8'h00;
		end
	end
	assign IRQ = irq_reg;
	assign WAKEUP_REQ = wreq_reg;
	assign PERIPH_REQ = preq_reg;
	assign WAKEUP_VECTOR = vec_reg;

	a_dt_sets_flag: assert property (@(posedge REF_CLK) disable iff (RST)
		ev_dt |=> pevt.flags[`IFW_BIT_DT])
		else $error("direct transfer flag missed");
	a_ad_sets_flag: assert property (@(posedge REF_CLK) disable iff (RST)
		$fell(CONVERSION_IN_PROGRESS) |=> pevt.flags[`IFW_BIT_AD])
		else $error("conversion flag missed");
	a_tfl_mode_only: assert property (@(posedge REF_CLK) disable iff (RST)
		(TIMER_F_16BIT && !pevt.flags[`IFW_BIT_TFL] && !wr_pflag) |=> !pevt.flags[`IFW_BIT_TFL])
		else $error("low timer flag set in 16-bit mode");
	a_tfh_match: assert property (@(posedge REF_CLK) disable iff (RST)
		(TIMER_F_16BIT && hi_eq && lo_eq) |=> pevt.flags[`IFW_BIT_TFH])
		else $error("high timer flag missed");
	a_ec_overflow: assert property (@(posedge REF_CLK) disable iff (RST)
		(!EVENT_COUNT_16BIT && EVENT_COUNT_LOW_OVF) |=> pevt.flags[`IFW_BIT_EC])
		else $error("counter flag missed");
	a_edge_polarity: assert property (@(posedge REF_CLK) disable iff (RST)
		(pin_valid_reg && WAKEUP_PIN_SELECT[0] && !wedge_reg[0] && $fell(WAKEUP_PIN[0]))
		|=> wevt.flags[0])
		else $error("falling wakeup edge missed");
	a_wake_gated: assert property (@(posedge REF_CLK) disable iff (RST)
		!en1_reg[`IFW_EN1_WAKE_BIT] && ((pevt.flags & en2_reg) == 8'h00) |=> !IRQ)
		else $error("request with sources disabled");
	a_wake_vector: assert property (@(posedge REF_CLK) disable iff (RST)
		wake_on |=> (WAKEUP_VECTOR == `IFW_WAKE_VECTOR))
		else $error("wrong wakeup vector");
	c_wake_irq: cover property (@(posedge REF_CLK) disable iff (RST) $rose(WAKEUP_REQ));
	c_periph_irq: cover property (@(posedge REF_CLK) disable iff (RST) $rose(PERIPH_REQ));
	c_write_done: cover property (@(posedge REF_CLK) disable iff (RST)
		S_AXI_BVALID && S_AXI_BREADY);
endmodule

// File: verif/ifw_periph_model.sv
`timescale 1ns/1ps
// Stand-in for peripherals and pins; after the time-0 setup every change lands by non-blocking assignment on an edge.
module ifw_periph_model (
	input wire logic clk,
	output logic SLEEP_DIRECT,
	output logic DIRECT_TRANSFER_ON,
	output logic CONVERSION_IN_PROGRESS,
	output logic TIMER_F_16BIT,
	output logic [7:0] TIMER_F_HIGH_COUNT,
	output logic [7:0] TIMER_F_LOW_COUNT,
	output logic [7:0] TIMER_F_HIGH_COMPARE,
	output logic [7:0] TIMER_F_LOW_COMPARE,
	output logic EVENT_COUNT_16BIT,
	output logic EVENT_COUNT_HIGH_OVF,
	output logic EVENT_COUNT_LOW_OVF,
	output logic [7:0] WAKEUP_PIN,
	output logic [7:0] WAKEUP_PIN_SELECT
);
	// Counts sit one above their compares, so no half matches in either mode while quiet.
	task automatic quiet();
		SLEEP_DIRECT <= 1'b0;
		CONVERSION_IN_PROGRESS <= 1'b0;
		EVENT_COUNT_HIGH_OVF <= 1'b0;
		EVENT_COUNT_LOW_OVF <= 1'b0;
		TIMER_F_HIGH_COUNT <= 8'h5b;
		TIMER_F_LOW_COUNT <= 8'ha6;
	endtask
	// Fixed compares keep the match cases readable.
	initial begin
		TIMER_F_HIGH_COMPARE = 8'h5a;
		TIMER_F_LOW_COMPARE = 8'ha5;
		DIRECT_TRANSFER_ON = 1'b0;
		TIMER_F_16BIT = 1'b0;
		EVENT_COUNT_16BIT = 1'b0;
		WAKEUP_PIN = 8'h00;
		WAKEUP_PIN_SELECT = 8'h00;
		quiet();
	end
	// One event for one cycle; code 11 leaves the high match standing until quiet is called.
	task automatic ev(input int k);
		@(posedge clk);
		DIRECT_TRANSFER_ON <= (k == 0);
		SLEEP_DIRECT <= (k <= 1);
		CONVERSION_IN_PROGRESS <= (k == 2);
		TIMER_F_16BIT <= (k inside {5, 6, 10});
		if (k inside {3, 5, 10, 11}) TIMER_F_HIGH_COUNT <= TIMER_F_HIGH_COMPARE;
		if (k inside {4, 5, 6}) TIMER_F_LOW_COUNT <= TIMER_F_LOW_COMPARE;
		EVENT_COUNT_16BIT <= (k inside {7, 8});
		EVENT_COUNT_HIGH_OVF <= (k == 7);
		EVENT_COUNT_LOW_OVF <= (k inside {8, 9});
		@(posedge clk);
		if (k != 11) quiet();
	endtask
	// Select settles one edge before the pins move, so no edge meets a changing select.
	task automatic pins(input logic [7:0] sel, input logic [7:0] v);
		@(posedge clk);
		WAKEUP_PIN_SELECT <= sel;
		@(posedge clk);
		WAKEUP_PIN <= v;
	endtask
endmodule

// File: verif/tb_irq_flags_wakeup_edge.sv
`timescale 1ns/1ps
`include "ifw_params.svh"
// Bus master, cycle model of the flags, and compares at every read and output check.
module tb_irq_flags_wakeup_edge;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rrsp;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, IRQ, WAKEUP_REQ, PERIPH_REQ;
	logic SLEEP_DIRECT, DIRECT_TRANSFER_ON, CONVERSION_IN_PROGRESS, TIMER_F_16BIT, sd_q, cip_q;
	logic [7:0] TIMER_F_HIGH_COUNT, TIMER_F_LOW_COUNT, TIMER_F_HIGH_COMPARE, TIMER_F_LOW_COMPARE;
	logic EVENT_COUNT_16BIT, EVENT_COUNT_HIGH_OVF, EVENT_COUNT_LOW_OVF;
	logic [7:0] WAKEUP_PIN, WAKEUP_PIN_SELECT, WAKEUP_VECTOR, pin_q, sel;
	int m_pf, m_wf, m_we, m_en1, m_en2, errors, check_count, cyc;

	ifw_top dut_u (.REF_CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
		.S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .SLEEP_DIRECT, .DIRECT_TRANSFER_ON,
		.CONVERSION_IN_PROGRESS, .TIMER_F_16BIT, .TIMER_F_HIGH_COUNT, .TIMER_F_LOW_COUNT,
		.TIMER_F_HIGH_COMPARE, .TIMER_F_LOW_COMPARE, .EVENT_COUNT_16BIT,
		.EVENT_COUNT_HIGH_OVF, .EVENT_COUNT_LOW_OVF, .WAKEUP_PIN, .WAKEUP_PIN_SELECT, .IRQ,
		.WAKEUP_REQ, .PERIPH_REQ, .WAKEUP_VECTOR);
	ifw_periph_model p_u (.clk(REF_CLK), .SLEEP_DIRECT, .DIRECT_TRANSFER_ON,
		.CONVERSION_IN_PROGRESS, .TIMER_F_16BIT, .TIMER_F_HIGH_COUNT, .TIMER_F_LOW_COUNT,
		.TIMER_F_HIGH_COMPARE, .TIMER_F_LOW_COMPARE, .EVENT_COUNT_16BIT,
		.EVENT_COUNT_HIGH_OVF, .EVENT_COUNT_LOW_OVF, .WAKEUP_PIN, .WAKEUP_PIN_SELECT);

	always #25 REF_CLK = ~REF_CLK;

	// Flag model; a set simply ORs in, so a later clear write cannot hide a standing event.
	always @(posedge REF_CLK) begin
		if (RST) begin
			m_pf = 0;
			m_wf = 0;
			m_we = 0;
			m_en1 = 0;
			m_en2 = 0;
		end else begin
			if (SLEEP_DIRECT && !sd_q && DIRECT_TRANSFER_ON) m_pf |= 'h80;
			if (!CONVERSION_IN_PROGRESS && cip_q) m_pf |= 'h40;
			if (TIMER_F_16BIT ? ({TIMER_F_HIGH_COUNT, TIMER_F_LOW_COUNT} ==
				{TIMER_F_HIGH_COMPARE, TIMER_F_LOW_COMPARE}) :
				(TIMER_F_HIGH_COUNT == TIMER_F_HIGH_COMPARE)) m_pf |= 'h08;
			if (!TIMER_F_16BIT && TIMER_F_LOW_COUNT == TIMER_F_LOW_COMPARE) m_pf |= 'h04;
			if (EVENT_COUNT_16BIT ? EVENT_COUNT_HIGH_OVF :
				(EVENT_COUNT_HIGH_OVF || EVENT_COUNT_LOW_OVF)) m_pf |= 'h01;
			m_wf |= WAKEUP_PIN_SELECT & ((m_we & WAKEUP_PIN & ~pin_q) | (~m_we & ~WAKEUP_PIN & pin_q));
		end
		sd_q = SLEEP_DIRECT;
		cip_q = CONVERSION_IN_PROGRESS;
		pin_q = WAKEUP_PIN;
	end

	// A hang ends the run as a failure.
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Write with address and data together; the model takes the write once the answer comes.
	task automatic wr(input logic [11:0] a, input int d);
		logic aw_s, w_s, b_s;
		@(posedge REF_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= 32'(d);
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		// Settled values before the rising edge are what that edge samples, avoiding a race.
		do begin
			@(negedge REF_CLK);
			aw_s = S_AXI_AWREADY;
			w_s = S_AXI_WREADY;
			b_s = S_AXI_BVALID;
			@(posedge REF_CLK);
			if (aw_s) S_AXI_AWVALID <= 1'b0;
			if (w_s) S_AXI_WVALID <= 1'b0;
		end while (!b_s);
		S_AXI_BREADY <= 1'b0;
		if (S_AXI_WSTRB[0]) case (a)
			`IFW_OFS_PFLAG: m_pf &= d;
			`IFW_OFS_WFLAG: m_wf &= d;
			`IFW_OFS_WEDGE: m_we = d & 'hff;
			`IFW_OFS_EN1: m_en1 = d & `IFW_EN1_MASK;
			`IFW_OFS_EN2: m_en2 = d & `IFW_PFLAG_MASK;
			default: ;
		endcase
	endtask

	task automatic rc(input logic [11:0] a, input int e);
		logic ar_s, r_s;
		@(posedge REF_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		// Data and response are taken as they stand before the handshake edge.
		do begin
			@(negedge REF_CLK);
			ar_s = S_AXI_ARREADY;
			r_s = S_AXI_RVALID;
			rdat = S_AXI_RDATA;
			rrsp = S_AXI_RRESP;
			@(posedge REF_CLK);
			if (ar_s) S_AXI_ARVALID <= 1'b0;
		end while (!r_s);
		S_AXI_RREADY <= 1'b0;
		chk(rdat, 32'(e));
		chk(32'(rrsp), (a > `IFW_OFS_VEC) ? 32'(`IFW_RESP_SLVERR) : 32'(`IFW_RESP_OKAY));
	endtask

	// Outputs are registered, so three edges let a flag or enable change reach them.
	task automatic outs();
		int wk, pr;
		repeat (3) @(posedge REF_CLK);
		wk = (m_wf != 0) && ((m_en1 >> `IFW_EN1_WAKE_BIT) & 1);
		pr = (m_pf & m_en2) != 0;
		chk(IRQ, 32'(wk || pr));
		chk(PERIPH_REQ, 32'(pr));
		chk(WAKEUP_REQ, 32'(wk));
		chk(WAKEUP_VECTOR, wk ? 32'(`IFW_WAKE_VECTOR) : 32'h0);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
		S_AXI_AWADDR = 12'h000;
		S_AXI_ARADDR = 12'h000;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'h1;
		void'($urandom(32'h33a5));
		repeat (5) @(posedge REF_CLK);
		RST <= 1'b0;
		rc(`IFW_OFS_PFLAG, 0);
		rc(`IFW_OFS_WFLAG, 0);
		rc(`IFW_OFS_WEDGE, `IFW_WEDGE_RESET);
		rc(`IFW_OFS_EN1, 0);
		rc(`IFW_OFS_EN2, 0);
		rc(`IFW_OFS_VEC, `IFW_WAKE_VECTOR);
		rc(12'h018, 0);
		$display("reset values done");
		for (int k = 0; k <= 10; k++) begin
			wr(`IFW_OFS_EN2, $urandom & `IFW_PFLAG_MASK);
			wr(`IFW_OFS_EN1, $urandom & `IFW_EN1_MASK);
			p_u.ev(k);
			outs();
			rc(`IFW_OFS_PFLAG, m_pf);
			wr(`IFW_OFS_PFLAG, `IFW_PFLAG_MASK);
			rc(`IFW_OFS_PFLAG, m_pf);
			wr(`IFW_OFS_PFLAG, 0);
			rc(`IFW_OFS_PFLAG, m_pf);
		end
		S_AXI_WSTRB <= 4'h0;
		wr(`IFW_OFS_WEDGE, 'hff);
		rc(`IFW_OFS_WEDGE, m_we);
		S_AXI_WSTRB <= 4'h1;
		$display("peripheral flags done");
		for (int i = 0; i < 12; i++) begin
			sel = 8'($urandom);
			wr(`IFW_OFS_WEDGE, $urandom & 'hff);
			wr(`IFW_OFS_EN1, $urandom & `IFW_EN1_MASK);
			p_u.pins(sel, 8'($urandom));
			p_u.pins(sel, 8'($urandom));
			outs();
			rc(`IFW_OFS_WFLAG, m_wf);
			wr(`IFW_OFS_WFLAG, $urandom & 'hff);
			rc(`IFW_OFS_WFLAG, m_wf);
		end
		$display("wakeup flags done");
		wr(`IFW_OFS_EN2, `IFW_PFLAG_MASK);
		p_u.ev(11);
		wr(`IFW_OFS_PFLAG, 0);
		outs();
		rc(`IFW_OFS_PFLAG, m_pf);
		p_u.quiet();
		wr(`IFW_OFS_PFLAG, 0);
		outs();
		rc(`IFW_OFS_PFLAG, m_pf);
		$display("set against clear done");
		test_done();
	end
endmodule
